// ==== bench/abm_monitor.sv ====
// pin timing checker for the bus cycle sequencer
module abm_monitor
   import abm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire abm_req_t req,
   input wire logic rsp_valid,
   input wire logic [ABM_FC_W-1:0] access_class_code,
   input wire logic [ABM_ADDR_W-1:0] addr_out,
   input wire logic addr_oe_n,
   input wire logic [ABM_DATA_W-1:0] data_out,
   input wire logic data_oe_n,
   input wire logic address_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic rw_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire take = req_valid && req_ready;
   wire strobes_off = address_strobe_n && upper_byte_strobe_n && lower_byte_strobe_n;
   a_class_dir: assert property (take |-> ##2 rw_reg && access_class_code == $past(req.fc, 2))
      else $error("class code or direction wrong in first state");
   a_addr_drive: assert property (take |-> ##3 !addr_oe_n && addr_out == $past(req.addr, 3))
      else $error("address not driven in second state");
   a_strobe_start: assert property (take |-> ##2 address_strobe_n ##1 !address_strobe_n)
      else $error("address strobe not asserted in third state");
   a_read_strobe: assert property (take && !req.write && req.lower |-> ##4 !lower_byte_strobe_n)
      else $error("read byte strobe late");
   a_write_order: assert property (take && req.write && req.upper |-> ##4 !rw_reg && upper_byte_strobe_n
      ##1 !data_oe_n && data_out == $past(req.wdata, 5) ##1 !upper_byte_strobe_n)
      else $error("write direction, data and strobe out of order");
   a_min_length: assert property (take |-> ##1 !rsp_valid [*7])
      else $error("cycle ended before four clocks");
   a_strobes_end: assert property (rsp_valid |-> strobes_off)
      else $error("strobes still asserted at cycle end");
   a_bus_release: assert property (rsp_valid |=> addr_oe_n && data_oe_n && rw_reg)
      else $error("bus not released after cycle end");
   c_read: cover property (take && !req.write);
   c_write: cover property (take && req.write);
   c_end: cover property (rsp_valid);
endmodule : abm_monitor

bind abm_seq abm_monitor mon (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
   .req(req), .rsp_valid(rsp_valid), .access_class_code(access_class_code), .addr_out(addr_out),
   .addr_oe_n(addr_oe_n), .data_out(data_out), .data_oe_n(data_oe_n), .address_strobe_n(address_strobe_n),
   .upper_byte_strobe_n(upper_byte_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n), .rw_reg(rw_reg));

// ==== bench/abm_slave.sv ====
// slave and bus control model answering the sequencer
module abm_slave
   import abm_pkg::*;
(
   input wire logic mclk,
   input wire logic address_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic rw_reg,
   input wire logic [ABM_ADDR_W-1:0] addr_out,
   input wire logic [ABM_DATA_W-1:0] data_out,
   input wire logic [1:0] mode,
   input wire logic [3:0] delay,
   output logic transfer_ack_n,
   output logic bus_fault_in_n = 1'b1,
   output logic halt_in_n = 1'b1,
   output logic [ABM_DATA_W-1:0] data_in = 16'h0000,
   output logic [ABM_DATA_W-1:0] wr_seen = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt = 4'h0;
   logic [3:0] hcnt = 4'h0;
   logic retried = 1'b0;
   logic slow_ack_n = 1'b1;
   logic fast_ack_n = 1'b1;
   // mode 0 ack, 1 fault, 2 retry once, 3 fast slave answering on the falling edge after the strobe
   assign transfer_ack_n = slow_ack_n & fast_ack_n;
   // the fast ack leads the data by half a state and drops half a state after the strobe does
   always @(negedge mclk) begin
      fast_ack_n <= address_strobe_n || mode != 2'h3;
   end
   always @(posedge mclk) begin
      if (address_strobe_n) begin
         cnt <= 4'h0;
         slow_ack_n <= 1'b1;
         bus_fault_in_n <= 1'b1;
         data_in <= ~data_in;
         hcnt <= hcnt + 4'h1;
         if (hcnt == 4'h6) halt_in_n <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
         if (rw_reg) data_in <= addr_out[15:0] ^ 16'h5A5A;
         if (!rw_reg && !upper_byte_strobe_n) wr_seen <= data_out;
         // answer delay+1 cycles after data is placed, never together with it
         if (cnt == delay + 4'h1) begin
            if (mode == 2'h1 || (mode == 2'h2 && !retried)) bus_fault_in_n <= 1'b0;
            else slow_ack_n <= 1'b0;
            if (mode == 2'h2 && !retried) begin
               halt_in_n <= 1'b0;
               hcnt <= 4'h0;
               retried <= 1'b1;
            end
         end
      end
   end
endmodule : abm_slave

// ==== bench/testbench.sv ====
// self-checking bench for the bus cycle sequencer
module testbench
   import abm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   abm_req_t req = '0;
   logic [1:0] mode = 2'h0;
   logic [3:0] delay = 4'h0;
   logic saw_halt = 1'b0;
   int failures = 0;
   int checks_done = 0;
   wire logic req_ready, rsp_valid, halted, ack_n, fault_n, halt_n, addr_oe_n, data_oe_n, astb_n, ub_n, lb_n, rw;
   wire abm_rsp_t rsp;
   wire logic [ABM_ADDR_W-1:0] addr;
   wire logic [ABM_DATA_W-1:0] din, dout, wr_seen;
   abm_seq dut (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp), .halted(halted), .transfer_ack_n(ack_n), .bus_fault_in_n(fault_n),
      .halt_in_n(halt_n), .access_class_code(), .addr_out(addr), .addr_oe_n(addr_oe_n), .data_in(din),
      .data_out(dout), .data_oe_n(data_oe_n), .address_strobe_n(astb_n), .upper_byte_strobe_n(ub_n),
      .lower_byte_strobe_n(lb_n), .rw_reg(rw));
   abm_slave slave (.mclk(mclk), .address_strobe_n(astb_n), .upper_byte_strobe_n(ub_n), .rw_reg(rw),
      .addr_out(addr), .data_out(dout), .mode(mode), .delay(delay), .transfer_ack_n(ack_n),
      .bus_fault_in_n(fault_n), .halt_in_n(halt_n), .data_in(din), .wr_seen(wr_seen));
   initial begin
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) if (halted === 1'b1) saw_halt <= 1'b1;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   // latency counts edges from the taking edge to the one that shows rsp_valid
   task automatic run(input logic w, input logic [23:0] a, input logic [15:0] wd, output int lat);
      repeat (2) @(posedge mclk);
      #1 req = '{w, 1'b1, 1'b1, 3'h5, a, wd};
      req_valid = 1'b1;
      @(posedge mclk);
      #1 req_valid = 1'b0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 300) begin
         @(posedge mclk);
         #1 lat++;
      end
      if (lat >= 300) begin
         failures++;
         stop_test();
      end
   endtask : run
   task automatic t_read();
      int lat;
      mode = 2'h3;
      run(1'b0, 24'h00A5A0, 16'h0000, lat);
      check("read length", lat, 8);
      check("read data", rsp.rdata, 16'hA5A0 ^ 16'h5A5A);
      $display("test read done");
   endtask : t_read
   task automatic t_wait();
      int l0, l4, l8;
      mode = 2'h0;
      run(1'b0, 24'h000010, 16'h0000, l0);
      delay = 4'h4;
      run(1'b0, 24'h000010, 16'h0000, l4);
      delay = 4'h8;
      run(1'b0, 24'h000010, 16'h0000, l8);
      check("two clock wait", l4 - l0, 4);
      check("four clock wait", l8 - l0, 8);
      $display("test wait done");
   endtask : t_wait
   task automatic t_write();
      int lat;
      delay = 4'h4;
      run(1'b1, 24'h123456, 16'hBEEF, lat);
      check("write data", wr_seen, 16'hBEEF);
      check("write end", rsp.how, ABM_END_OK);
      $display("test write done");
   endtask : t_write
   task automatic t_fault();
      int lat;
      mode = 2'h1;
      delay = 4'h2;
      run(1'b0, 24'h000100, 16'h0000, lat);
      check("fault end", rsp.how, ABM_END_FAULT);
      $display("test fault done");
   endtask : t_fault
   task automatic t_retry();
      int lat;
      mode = 2'h2;
      run(1'b0, 24'h000200, 16'h0000, lat);
      check("halt seen", saw_halt, 1'b1);
      check("rerun end", rsp.how, ABM_END_OK);
      check("rerun data", rsp.rdata, 16'h0200 ^ 16'h5A5A);
      $display("test retry done");
   endtask : t_retry
   initial begin
      repeat (6) @(posedge mclk);
      #1 nrst = 1'b1;
      check("idle pins", {astb_n, ub_n, lb_n, rw, req_ready, addr_oe_n, data_oe_n}, 7'h7F);
      t_read();
      t_wait();
      t_write();
      t_fault();
      t_retry();
      stop_test();
   end
endmodule : testbench

// ==== logic/abm_pkg.sv ====
// package for the asynchronous bus master cycle sequencer
package abm_pkg;
   localparam int ABM_ADDR_W = 24;
   localparam int ABM_DATA_W = 16;
   localparam int ABM_FC_W = 3;
   localparam int ABM_SYNC_STAGES = 2;
   // reset values of the pin outputs
   localparam logic ABM_RW_IDLE = 1'b1;
   localparam logic [ABM_FC_W-1:0] ABM_FC_RESET = 3'h0;
   localparam logic [ABM_ADDR_W-1:0] ABM_ADDR_RESET = 24'h000000;
   localparam logic [ABM_DATA_W-1:0] ABM_DATA_RESET = 16'h0000;
   localparam logic [1:0] ABM_SYNC_RESET = 2'h0;
   localparam logic [31:0] ABM_WAIT_RESET = 32'h00000000;

   // half-clock bus states; one half-clock is one mclk cycle
   typedef enum logic [3:0] {
      ABM_IDLE = 4'h0,
      ABM_S0 = 4'h1,
      ABM_S1 = 4'h2,
      ABM_S2 = 4'h3,
      ABM_S3 = 4'h4,
      ABM_S4 = 4'h5,
      ABM_SW = 4'h6,
      ABM_S5 = 4'h7,
      ABM_S6 = 4'h8,
      ABM_S7 = 4'h9,
      ABM_HALTW = 4'hA
   } abm_state_t;

   typedef enum logic [1:0] {
      ABM_END_OK = 2'h0,
      ABM_END_FAULT = 2'h1,
      ABM_END_RETRY = 2'h2
   } abm_end_t;

   typedef struct packed {
      logic write;
      logic upper;
      logic lower;
      logic [ABM_FC_W-1:0] fc;
      logic [ABM_ADDR_W-1:0] addr;
      logic [ABM_DATA_W-1:0] wdata;
   } abm_req_t;

   typedef struct packed {
      abm_end_t how;
      logic [ABM_DATA_W-1:0] rdata;
   } abm_rsp_t;
endpackage : abm_pkg

// ==== logic/abm_seq.sv ====
// bus cycle sequencer: eight half-clock states plus whole-clock waits
// What this block does
// R1 - four clocks, eight states, whole-clock waits
// R2 - S0 drives class code, direction high
// R3 - S1 drives address
// R4 - S2 address strobe; read strobes, write direction low
// R5 - S3 write drives data
// R6 - S4 write asserts byte strobes
// R7 - responses ignored before end of S4
// R8 - ack or fault advances to S5
// R9 - otherwise wait states in S4
// R10 - no maximum wait
// R11 - S5 changes nothing
// R12 - slave read data valid in S6; not done, the data is taken from the bus at the end of S4
// R13 - S7 latch read data, negate strobes
// R14 - slave acks after data ready
// R15 - slave releases ack promptly
// R16 - fault alone aborts, with halt retries
// R17 - pseudo-async ack may lead data
// R18 - late fault within bounded delay; not done, only the S4 sample counts
// R19 - address strobe starts cycle, byte strobes data
// R20 - after S7 float address, data; direction high
// R21 - fault plus halt reruns after halt release
// R22 - fault alone ends cycle with error
// R23 - reset: idle, strobes negated, direction high
module abm_seq
   import abm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic req_valid,
   output logic req_ready,
   input wire abm_req_t req,
   output logic rsp_valid,
   output abm_rsp_t rsp,
   output logic halted,
   input wire logic transfer_ack_n,
   input wire logic bus_fault_in_n,
   input wire logic halt_in_n,
   output logic [ABM_FC_W-1:0] access_class_code,
   output logic [ABM_ADDR_W-1:0] addr_out,
   output logic addr_oe_n,
   input wire logic [ABM_DATA_W-1:0] data_in,
   output logic [ABM_DATA_W-1:0] data_out,
   output logic data_oe_n,
   output logic address_strobe_n,
   output logic upper_byte_strobe_n,
   output logic lower_byte_strobe_n,
   output logic rw_reg
);
   abm_state_t state_reg, state_next;
   abm_req_t cur_reg;
   abm_end_t how_reg;
   logic [ABM_DATA_W-1:0] din_s1_reg, din_reg;
   logic [2:0] resp_s;
   logic ack_s, fault_s, halt_s, resp_seen;
   logic take_req;
   logic s4_done;
   logic end_retry;
   logic end_fault;
   logic enter_s7;
   logic enter_halt;
   logic rsp_ok;
   logic first_s4;
   logic upper_n_next;
   logic lower_n_next;
   logic [ABM_FC_W-1:0] fc_next;

   // ack, fault and halt are asynchronous: two flops before use
   abm_sync #(.WIDTH(3)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_in({~transfer_ack_n, ~bus_fault_in_n, ~halt_in_n}),
      .sync_out(resp_s)
   );
   assign ack_s = resp_s[2];
   assign fault_s = resp_s[1];
   assign halt_s = resp_s[0];
   assign resp_seen = ack_s | fault_s; // R8

   // the data bus also passes two flops; the slave must have it steady at the end of S4
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         din_s1_reg <= ABM_DATA_RESET;
         din_reg <= ABM_DATA_RESET;
      end else begin
         din_s1_reg <= data_in;
         din_reg <= din_s1_reg;
      end
   end

   // one request at a time: ready only while idle, so nothing queues
   assign req_ready = (state_reg == ABM_IDLE);

   // decoded events of the cycle; the flops below stay short
   assign take_req = (state_reg == ABM_IDLE) && req_valid;
   // two flops of lag: ack must be low by the edge entering S3 to end S4 without a wait
   assign s4_done = (state_reg == ABM_S4) && resp_seen; // R7 R8
   assign end_retry = fault_s && halt_s; // R21
   assign end_fault = fault_s && !halt_s; // R22
   assign enter_s7 = (state_next == ABM_S7);
   assign enter_halt = (state_next == ABM_HALTW);
   assign rsp_ok = (how_reg != ABM_END_RETRY);
   // on the taking edge the held request is not loaded yet, so the code comes from the request itself
   assign fc_next = take_req ? req.fc : cur_reg.fc; // R2
   assign first_s4 = (state_next == ABM_S4) && (state_reg == ABM_S3); // R6
   assign upper_n_next = ~cur_reg.upper;
   assign lower_n_next = ~cur_reg.lower;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ABM_IDLE: if (req_valid) state_next = ABM_S0; // R23
         ABM_S0: state_next = ABM_S1; // R1
         ABM_S1: state_next = ABM_S2;
         ABM_S2: state_next = ABM_S3;
         ABM_S3: state_next = ABM_S4;
         // responses only looked at when S4 ends
         ABM_S4: state_next = resp_seen ? ABM_S5 : ABM_SW; // R7 R8 R9
         // one wait half pair: SW then back to S4 makes a whole clock
         // no wait limit: a slave that never answers stalls the bus until reset
         ABM_SW: state_next = ABM_S4; // R9 R10
         ABM_S5: state_next = ABM_S6; // R11
         ABM_S6: state_next = ABM_S7; // R12
         ABM_S7: state_next = (how_reg == ABM_END_RETRY) ? ABM_HALTW : ABM_IDLE; // R20
         ABM_HALTW: if (!halt_s) state_next = ABM_S0; // R21
         default: state_next = ABM_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ABM_IDLE;
         cur_reg <= '0;
         how_reg <= ABM_END_OK;
      end else begin
         state_reg <= state_next;
         if (take_req) cur_reg <= req;
         // only the S4 sample decides: a fault arriving after the ack is not seen
         if (s4_done) begin // R18
            if (end_retry) how_reg <= ABM_END_RETRY; // R21
            else if (end_fault) how_reg <= ABM_END_FAULT; // R22
            else how_reg <= ABM_END_OK;
         end
      end
   end

   // pin outputs move on the edge that enters each state
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         access_class_code <= ABM_FC_RESET;
         addr_out <= ABM_ADDR_RESET;
         addr_oe_n <= 1'b1;
         data_out <= ABM_DATA_RESET;
         data_oe_n <= 1'b1;
         address_strobe_n <= 1'b1;
         upper_byte_strobe_n <= 1'b1;
         lower_byte_strobe_n <= 1'b1;
         rw_reg <= ABM_RW_IDLE; // R23
      end else begin
         case (state_next)
            ABM_S0: begin
               access_class_code <= fc_next; // R2
               rw_reg <= ABM_RW_IDLE; // R2
               addr_oe_n <= 1'b1;
               data_oe_n <= 1'b1;
            end
            ABM_S1: begin
               addr_out <= cur_reg.addr; // R3
               addr_oe_n <= 1'b0; // R3
            end
            ABM_S2: begin
               address_strobe_n <= 1'b0; // R4 R19
               if (cur_reg.write) rw_reg <= 1'b0; // R4
               else begin
                  upper_byte_strobe_n <= upper_n_next; // R4
                  lower_byte_strobe_n <= lower_n_next; // R4
               end
            end
            // data goes out a state before the byte strobes so it is settled when they fall
            ABM_S3: if (cur_reg.write) begin
               data_out <= cur_reg.wdata; // R5
               data_oe_n <= 1'b0; // R5
            end
            ABM_S4: if (cur_reg.write && first_s4) begin
               upper_byte_strobe_n <= upper_n_next; // R6 R19
               lower_byte_strobe_n <= lower_n_next; // R6 R19
            end
            // all strobes drop together so the slave sees one end of cycle
            ABM_S7: begin
               address_strobe_n <= 1'b1; // R13
               upper_byte_strobe_n <= 1'b1; // R13
               lower_byte_strobe_n <= 1'b1; // R13
            end
            // the bus floats between cycles; the next S1 drives the address again, S3 the write data
            ABM_IDLE, ABM_HALTW: begin
               addr_oe_n <= 1'b1; // R20
               data_oe_n <= 1'b1; // R20
               rw_reg <= ABM_RW_IDLE; // R20
            end
            // S5, S6 and the wait states leave every pin as it is
            default: begin
            end
         endcase
      end
   end

   // read data latched entering S7; answer given with the cycle's end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rsp <= '0;
         rsp_valid <= 1'b0;
         halted <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (enter_s7) begin
            rsp.how <= how_reg;
            if (!cur_reg.write) rsp.rdata <= din_reg; // R13
            // a retry gives no answer: the same request runs again once halt lifts
            rsp_valid <= rsp_ok;
         end
         halted <= enter_halt;
      end
   end
endmodule : abm_seq

// ==== logic/abm_sync.sv ====
// two-flop synchroniser for the asynchronous response inputs
module abm_sync
   import abm_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : abm_sync
